// File: verilog/tdm_pkg.sv
// Constants and types for the 2B+D bus framer with D-channel port.
// Assumes a 25 MHz system clock and a separate bus bit clock.
// Notes on behaviour
// - Separate transmit and receive frame syncs
// - Master drives both syncs coincident
// - Slave syncs accepted independently or tied
// - Slave accepts 512 kHz to 8.192 MHz
// - Long frame sync spans whole transfer
// - Master moves in and out together
// - Select pin: one master, zero slave
// - Master bit clock 512k, 2.048M, 2.56M
// - GCI enable bit gives GCI timing
// - GCI: four signals, clock twice rate
// - GCI output driven only for 2B+D
// - GCI channel from slot bits 2:0
// - D port only serial, short or GCI
// - D port enable bit, off after reset
// - D port clock gated at D bits
// - D port input buffered, output never floats
// - D port on: bus D bits skipped
// - Assigner places D port at slot
// - Frame: eight B1, eight B2, two D
// - Rate decode of the two select bits
// - Three bits select the five formats
package tdm_pkg;
	localparam int MCLK_HZ = 25000000;
	localparam int FRAME_HZ = 8000;
	localparam int R2560K_HZ = 2560000;
	localparam int R2048K_HZ = 2048000;
	localparam int R512K_HZ = 512000;
	localparam logic [9:0] LEN_2560K = 10'(R2560K_HZ / FRAME_HZ);
	localparam logic [9:0] LEN_2048K = 10'(R2048K_HZ / FRAME_HZ);
	localparam logic [9:0] LEN_512K = 10'(R512K_HZ / FRAME_HZ);
	localparam logic [4:0] HALF_2560K = 5'(MCLK_HZ / (2 * R2560K_HZ));
	localparam logic [4:0] HALF_2048K = 5'(MCLK_HZ / (2 * R2048K_HZ));
	localparam logic [4:0] HALF_512K = 5'(MCLK_HZ / (2 * R512K_HZ));
	localparam int TSA_HI = 7;
	localparam int TSA_LO = 5;
	localparam int GCI_EN_BIT = 3;
	localparam int LONG_BIT = 3;
	localparam int RATE_BIT = 4;
	localparam int EIGHT_BIT = 0;
	localparam int BR_RATE_BIT = 2;
	localparam int DPORT_EN_BIT = 0;
	localparam int GCI_SEL_HI = 2;
	localparam logic [9:0] CNT_IDLE = 10'h3ff;
	localparam logic [9:0] LONG_FS_CYCLES = 10'h013;
	localparam logic [4:0] LAST_IDX = 5'h11;
	localparam logic [4:0] D1_IDX = 5'h10;
	typedef logic [17:0] word_type;
	localparam word_type WORD_RESET = 18'h00000;
	typedef enum logic [2:0] {
		FMT_SHORT10, FMT_SHORT8, FMT_LONG10, FMT_LONG8, FMT_GCI
	} fmt_type;
	typedef enum logic [1:0] {RATE_2560K, RATE_2048K, RATE_512K} rate_type;
	typedef struct packed {
		logic [7:0] format_tsa_control;
		logic [7:0] frame_clock_control;
		logic [7:0] bus_format_control;
		logic [7:0] port_align_control;
		logic [7:0] din_d_slot_gci_select;
		logic [7:0] dout_d_slot;
		logic serial_control_port;
		logic master;
	} cfg_type;
	localparam cfg_type CFG_RESET = '0;
	typedef struct packed {
		logic valid;
		logic is_d;
		logic [4:0] idx;
	} slot_type;

	function automatic rate_type rate_of(input cfg_type c);
		rate_type r;
		if (c.frame_clock_control[RATE_BIT]) begin
			r = RATE_512K;
		end else if (c.bus_format_control[BR_RATE_BIT]) begin
			r = RATE_2048K;
		end else begin
			r = RATE_2560K;
		end
		return r;
	endfunction : rate_of
endpackage : tdm_pkg

// File: verilog/tdm_2bd_bus_framing_dport.sv
// 2B+D time-division bus framer: frame syncs, bit timing, D-channel port.
// Config and words on mclk; bus logic on the bus bit clock.
`timescale 1ns/1ns
`default_nettype none
module tdm_2bd_bus_framing_dport (
	input wire logic mclk,
	input wire logic rst,
	input wire logic master_select,
	input wire tdm_pkg::cfg_type cfg,
	input wire tdm_pkg::word_type dn_word,
	input wire logic dn_valid,
	output logic dn_ready,
	output tdm_pkg::word_type up_word,
	output logic up_valid,
	input wire logic bus_bit_clock,
	output logic bus_bit_clock_out,
	output logic bus_bit_clock_oe,
	input wire logic tx_frame_sync_in,
	output logic tx_frame_sync_out,
	output logic tx_frame_sync_oe,
	input wire logic rx_frame_sync_in,
	output logic rx_frame_sync_out,
	output logic rx_frame_sync_oe,
	input wire logic bus_data_in,
	output logic bus_data_out,
	output logic bus_data_out_oe,
	input wire logic dport_data_in,
	output logic dport_data_out,
	output logic dport_gated_clock
);
	import tdm_pkg::*;

	// System clock side
	logic ms_s1_reg, ms_s2_reg, clk_oe_reg, bclk_reg;
	logic [4:0] div_reg, half_sel;
	cfg_type cfg_m;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ms_s1_reg <= 1'b0;
			ms_s2_reg <= 1'b0;
		end else begin
			ms_s1_reg <= master_select;
			ms_s2_reg <= ms_s1_reg;
		end
	end
	always_comb begin
		cfg_m = cfg;
		cfg_m.master = ms_s2_reg;
		case (rate_of(cfg))
			RATE_512K: half_sel = HALF_512K;
			RATE_2048K: half_sel = HALF_2048K;
			default: half_sel = HALF_2560K;
		endcase
	end
	// Master bit clock divider
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			div_reg <= 5'h00;
			bclk_reg <= 1'b0;
			clk_oe_reg <= 1'b0;
		end else begin
			clk_oe_reg <= ms_s2_reg;
			if (!ms_s2_reg) begin
				div_reg <= 5'h00;
				bclk_reg <= 1'b0;
			end else if (div_reg >= half_sel - 5'h01) begin
				div_reg <= 5'h00;
				bclk_reg <= ~bclk_reg;
			end else begin
				div_reg <= div_reg + 5'h01;
			end
		end
	end
	assign bus_bit_clock_out = bclk_reg;
	assign bus_bit_clock_oe = clk_oe_reg;

	// Word handshakes toward the bus side
	word_type dn_hold_reg, up_word_reg, up_hold_reg, dn_link_reg;
	logic dn_req_reg, dn_ready_reg, ack_s1_reg, ack_s2_reg, dn_ack_reg;
	logic up_tgl_reg, up_s1_reg, up_s2_reg, up_s3_reg, up_valid_reg;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ack_s1_reg <= 1'b0;
			ack_s2_reg <= 1'b0;
			dn_req_reg <= 1'b0;
			dn_ready_reg <= 1'b0;
			dn_hold_reg <= WORD_RESET;
		end else begin
			ack_s1_reg <= dn_ack_reg;
			ack_s2_reg <= ack_s1_reg;
			if (dn_valid && dn_ready_reg) begin
				dn_hold_reg <= dn_word;
				dn_req_reg <= ~dn_req_reg;
				dn_ready_reg <= 1'b0;
			end else if (ack_s2_reg == dn_req_reg) begin
				dn_ready_reg <= 1'b1;
			end
		end
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			up_s1_reg <= 1'b0;
			up_s2_reg <= 1'b0;
			up_s3_reg <= 1'b0;
			up_valid_reg <= 1'b0;
			up_word_reg <= WORD_RESET;
		end else begin
			up_s1_reg <= up_tgl_reg;
			up_s2_reg <= up_s1_reg;
			up_s3_reg <= up_s2_reg;
			up_valid_reg <= up_s2_reg ^ up_s3_reg;
			if (up_s2_reg ^ up_s3_reg) begin
				up_word_reg <= up_hold_reg;
			end
		end
	end
	assign dn_ready = dn_ready_reg;
	assign up_word = up_word_reg;
	assign up_valid = up_valid_reg;

	// Bus side: configuration and decode
	cfg_type cfg_s1_reg, cfg_l;
	fmt_type fmt;
	logic gci, longf, dport_en, tsa_on;
	logic [9:0] flen;
	always_ff @(posedge bus_bit_clock or posedge rst) begin
		if (rst) begin
			cfg_s1_reg <= CFG_RESET;
			cfg_l <= CFG_RESET;
		end else begin
			cfg_s1_reg <= cfg_m;
			cfg_l <= cfg_s1_reg;
		end
	end
	always_comb begin
		if (cfg_l.format_tsa_control[GCI_EN_BIT]) begin
			fmt = FMT_GCI;
		end else if (cfg_l.frame_clock_control[LONG_BIT]) begin
			fmt = cfg_l.bus_format_control[EIGHT_BIT] ? FMT_LONG8 : FMT_LONG10;
		end else begin
			fmt = cfg_l.bus_format_control[EIGHT_BIT] ? FMT_SHORT8 : FMT_SHORT10;
		end
		case (rate_of(cfg_l))
			RATE_512K: flen = LEN_512K;
			RATE_2048K: flen = LEN_2048K;
			default: flen = LEN_2560K;
		endcase
	end
	assign gci = (fmt == FMT_GCI);
	assign longf = (fmt == FMT_LONG8) || (fmt == FMT_LONG10);
	assign tsa_on = |cfg_l.format_tsa_control[TSA_HI:TSA_LO];
	assign dport_en = cfg_l.port_align_control[DPORT_EN_BIT] &&
		cfg_l.serial_control_port && !longf;

	function automatic slot_type slot_of(input logic [9:0] cnt,
		input fmt_type f, input logic [2:0] ch, input logic tsa_d,
		input logic [7:0] tslot);
		slot_type s;
		logic [9:0] p;
		s = '0;
		p = cnt;
		if (f == FMT_GCI) begin
			p = {1'b0, cnt[9:1]} - {2'b00, ch, 5'h00};
		end
		case (f)
			FMT_SHORT10, FMT_LONG10: begin
				if (p < 10'd17) begin
					s.valid = 1'b1;
					s.is_d = (p == 10'd8);
					s.idx = (p < 10'd8) ? p[4:0] : 5'(p - 10'd1);
					if (p == 10'd8) s.idx = D1_IDX;
				end else if (p == 10'd17) begin
					s = '{1'b1, 1'b1, LAST_IDX};
				end
			end
			FMT_GCI: begin
				if (p < 10'd16) begin
					s = '{1'b1, 1'b0, p[4:0]};
				end else if (p == 10'd24 || p == 10'd25) begin
					s = '{1'b1, 1'b1, 5'(p - 10'd8)};
				end
			end
			default: begin
				if (p < 10'd18) begin
					s = '{1'b1, p >= 10'd16, p[4:0]};
				end
			end
		endcase
		if (tsa_d) begin
			if (s.is_d) s = '0;
			if (cnt[9:1] == {1'b0, tslot}) begin
				s = '{1'b1, 1'b1, cnt[0] ? LAST_IDX : D1_IDX};
			end
		end
		return s;
	endfunction : slot_of

	function automatic logic [4:0] bitpos(input logic [4:0] idx);
		return 5'(LAST_IDX - idx);
	endfunction : bitpos

	// Bus side: frame counters, sampled on the falling edge
	logic fs_out_reg, fs_oe_reg, tx_fs, rx_fs, tx_start, rx_start;
	logic tx_prev_reg, rx_prev_reg, tx_take, gate_en_reg, dp_first_reg;
	logic [9:0] tx_cnt_reg, rx_cnt_reg, rx_cnt_next, mcnt_reg, mcnt_next;
	logic [1:0] dbuf_reg;
	logic req_s1_reg, req_s2_reg, req_s3_reg;
	slot_type tx_slot, rx_slot, rx_nslot;
	word_type tx_asm_reg, asm_next, rx_word_reg;
	assign tx_fs = cfg_l.master ? fs_out_reg : tx_frame_sync_in;
	// GCI frame sync arrives on the transmit sync pin
	assign rx_fs = cfg_l.master ? fs_out_reg :
		(gci ? tx_frame_sync_in : rx_frame_sync_in);
	assign tx_start = longf ? (tx_fs && !tx_prev_reg) : tx_fs;
	assign rx_start = longf ? (rx_fs && !rx_prev_reg) : rx_fs;
	assign rx_cnt_next = rx_start ? 10'h000 :
		((rx_cnt_reg == CNT_IDLE) ? rx_cnt_reg : rx_cnt_reg + 10'h001);
	assign tx_slot = slot_of(tx_cnt_reg, fmt,
		cfg_l.din_d_slot_gci_select[GCI_SEL_HI:0], 1'b0, 8'h00);
	assign rx_slot = slot_of(rx_cnt_reg, fmt,
		cfg_l.din_d_slot_gci_select[GCI_SEL_HI:0], tsa_on && dport_en,
		cfg_l.dout_d_slot);
	assign rx_nslot = slot_of(rx_cnt_next, fmt,
		cfg_l.din_d_slot_gci_select[GCI_SEL_HI:0], tsa_on && dport_en,
		cfg_l.dout_d_slot);
	assign tx_take = tx_slot.valid && (!gci || tx_cnt_reg[0]);
	always_comb begin
		asm_next = tx_asm_reg;
		if (tx_take && !(tx_slot.is_d && dport_en)) begin
			asm_next[bitpos(tx_slot.idx)] = bus_data_in;
		end
	end
	// Transmit direction: bus input toward the framer
	always_ff @(negedge bus_bit_clock or posedge rst) begin
		if (rst) begin
			tx_prev_reg <= 1'b0;
			tx_cnt_reg <= CNT_IDLE;
			tx_asm_reg <= WORD_RESET;
			up_hold_reg <= WORD_RESET;
			up_tgl_reg <= 1'b0;
		end else begin
			tx_prev_reg <= tx_fs;
			if (tx_start) begin
				tx_cnt_reg <= 10'h000;
			end else if (tx_cnt_reg != CNT_IDLE) begin
				tx_cnt_reg <= tx_cnt_reg + 10'h001;
			end
			tx_asm_reg <= asm_next;
			if (tx_take && tx_slot.idx == LAST_IDX) begin
				up_hold_reg <= dport_en ? {asm_next[17:2], dbuf_reg} : asm_next;
				up_tgl_reg <= ~up_tgl_reg;
			end
		end
	end
	// Receive direction: words from the deframer, D port capture
	always_ff @(negedge bus_bit_clock or posedge rst) begin
		if (rst) begin
			rx_prev_reg <= 1'b0;
			rx_cnt_reg <= CNT_IDLE;
			rx_word_reg <= WORD_RESET;
			req_s1_reg <= 1'b0;
			req_s2_reg <= 1'b0;
			req_s3_reg <= 1'b0;
			dn_link_reg <= WORD_RESET;
			dn_ack_reg <= 1'b0;
			gate_en_reg <= 1'b0;
			dp_first_reg <= 1'b0;
			dbuf_reg <= 2'b00;
		end else begin
			rx_prev_reg <= rx_fs;
			rx_cnt_reg <= rx_cnt_next;
			req_s1_reg <= dn_req_reg;
			req_s2_reg <= req_s1_reg;
			req_s3_reg <= req_s2_reg;
			if (req_s2_reg != req_s3_reg) begin
				dn_link_reg <= dn_hold_reg;
				dn_ack_reg <= req_s2_reg;
			end
			if (rx_start) begin
				rx_word_reg <= dn_link_reg;
			end
			gate_en_reg <= dport_en && rx_nslot.valid && rx_nslot.is_d &&
				(!gci || !rx_cnt_next[0]);
			if (gate_en_reg && rx_slot.idx == D1_IDX) begin
				dp_first_reg <= dport_data_in;
			end else if (gate_en_reg) begin
				dbuf_reg <= {dp_first_reg, dport_data_in};
			end
		end
	end

	// Bus side: master sync and output launch on the rising edge
	assign mcnt_next = (mcnt_reg >= flen - 10'h001) ? 10'h000 :
		mcnt_reg + 10'h001;
	always_ff @(posedge bus_bit_clock or posedge rst) begin
		if (rst) begin
			mcnt_reg <= 10'h000;
			fs_out_reg <= 1'b0;
			fs_oe_reg <= 1'b0;
		end else begin
			fs_oe_reg <= cfg_l.master;
			if (!cfg_l.master) begin
				mcnt_reg <= 10'h000;
				fs_out_reg <= 1'b0;
			end else begin
				mcnt_reg <= mcnt_next;
				fs_out_reg <= longf ? (mcnt_next < LONG_FS_CYCLES) :
					(mcnt_next == 10'h000);
			end
		end
	end
	assign tx_frame_sync_out = fs_out_reg;
	assign rx_frame_sync_out = fs_out_reg;
	assign tx_frame_sync_oe = fs_oe_reg;
	assign rx_frame_sync_oe = fs_oe_reg;

	logic dout_reg, dout_oe_reg, dpo_reg;
	always_ff @(posedge bus_bit_clock or posedge rst) begin
		if (rst) begin
			dout_reg <= 1'b0;
			dout_oe_reg <= 1'b0;
			dpo_reg <= 1'b0;
		end else begin
			dout_oe_reg <= rx_slot.valid &&
				!(rx_slot.is_d && dport_en);
			if (rx_slot.valid) begin
				dout_reg <= rx_word_reg[bitpos(rx_slot.idx)];
			end
			if (rx_slot.valid && rx_slot.is_d && dport_en) begin
				dpo_reg <= rx_word_reg[bitpos(rx_slot.idx)];
			end
		end
	end
	assign bus_data_out = dout_reg;
	assign bus_data_out_oe = dout_oe_reg;
	assign dport_data_out = dpo_reg;
	// Gate enable changes only while the bit clock is low
	assign dport_gated_clock = bus_bit_clock & gate_en_reg;

	a_master_clk_oe: assert property (@(posedge mclk) disable iff (rst)
		$rose(ms_s2_reg) |=> clk_oe_reg)
		else $error("bit clock not driven in master mode");
	a_rate_toggle: assert property (@(posedge mclk) disable iff (rst)
		(ms_s2_reg && $changed(bclk_reg) && $past(ms_s2_reg)) |->
		$past(div_reg) == $past(half_sel) - 5'h01)
		else $error("bit clock half period wrong");
	a_sync_pair: assert property (@(posedge bus_bit_clock) disable iff (rst)
		fs_oe_reg |-> tx_frame_sync_oe && rx_frame_sync_oe &&
		tx_frame_sync_out == rx_frame_sync_out)
		else $error("master syncs not coincident");
	a_long_sync: assert property (@(posedge bus_bit_clock) disable iff (rst)
		(longf && $rose(fs_out_reg) && mcnt_reg == 10'h000) |->
		##18 fs_out_reg)
		else $error("long frame sync ended early");
	a_gci_float: assert property (@(posedge bus_bit_clock) disable iff (rst)
		(gci && !rx_slot.valid) |=> !bus_data_out_oe)
		else $error("output driven outside GCI data");
	a_dport_float: assert property (@(posedge bus_bit_clock) disable iff (rst)
		(dport_en && rx_slot.valid && rx_slot.is_d) |=> !bus_data_out_oe)
		else $error("bus output driven in D port slot");
	a_dport_off: assert property (@(negedge bus_bit_clock) disable iff (rst)
		gate_en_reg |-> $past(dport_en))
		else $error("D port clock while disabled");
	a_frame_start: assert property (@(negedge bus_bit_clock) disable iff (rst)
		(rx_fs && !longf) |=> rx_cnt_reg == 10'h000)
		else $error("short frame count not restarted");
	a_up_pulse: assert property (@(posedge mclk) disable iff (rst)
		up_valid_reg |=> !up_valid_reg)
		else $error("up word strobe longer than one cycle");
endmodule : tdm_2bd_bus_framing_dport
`default_nettype wire

// File: verif/tdm_partner.sv
// Far-side bus controller: free bit clock, tied syncs, serial data.
// Assumes the framer is bus slave while this model's clock is in use.
`timescale 1ns/1ns
`default_nettype none
module tdm_partner (
	output logic bclk,
	input wire tdm_pkg::fmt_type fmt,
	input wire logic [2:0] ch,
	input wire logic dport_on,
	input wire tdm_pkg::word_type in_word,
	output logic sync,
	output logic sdata,
	output logic ddata,
	input wire logic dev_data,
	input wire logic dev_oe,
	input wire logic dev_dport,
	input wire logic dev_dclk,
	output logic [22:0] got,
	output logic strobe
);
	import tdm_pkg::*;
	int cnt;
	int code;
	logic bad;
	logic [3:0] pulses;
	word_type w;
	word_type acc;
	initial begin
		bclk = 1'b0;
		sync = 1'b0;
		sdata = 1'b0;
		ddata = 1'b0;
		strobe = 1'b0;
		cnt = 0;
		bad = 1'b0;
		pulses = 4'h0;
		forever #6 bclk = ~bclk;
	end
	// Twice the word bit index, plus one on its last bit clock
	function automatic int slot_of(input int c);
		int b;
		int s;
		int wd;
		slot_of = -1;
		for (int j = 0; j < 18; j++) begin
			b = (j < 8 || j == 17) ? j : (j == 16) ? 8 : j + 1;
			if (fmt inside {FMT_SHORT8, FMT_LONG8}) begin
				b = j;
			end
			wd = (fmt == FMT_GCI) ? 2 : 1;
			if (fmt == FMT_GCI) begin
				b = ch * 32 + ((j < 16) ? j : j + 8);
			end
			s = wd * b + 1;
			if (c >= s && c < s + wd) begin
				slot_of = 2 * j + ((c == s + wd - 1) ? 1 : 0);
			end
		end
	endfunction : slot_of
	always @(posedge bclk) begin
		cnt = (cnt == 127) ? 0 : cnt + 1;
		if (cnt == 0) begin
			w = in_word;
			bad = 1'b0;
			pulses = 4'h0;
		end
		code = slot_of(cnt);
		sync <= cnt == 0 || (fmt inside {FMT_LONG8, FMT_LONG10} && cnt < 19);
		if (code >= 0 && !(dport_on && code >= 32)) begin
			sdata <= w[17 - code / 2];
		end else begin
			sdata <= ~sdata;
		end
		ddata <= (code >= 32) ? w[17 - code / 2] : ~ddata;
	end
	always @(posedge dev_dclk) begin
		pulses = pulses + 4'h1;
	end
	always @(negedge bclk) begin
		code = slot_of(cnt);
		if (dev_oe !== (code >= 0 && !(dport_on && code >= 32))) begin
			bad = 1'b1;
		end
		if (code >= 0 && code % 2 == 1) begin
			acc[17 - code / 2] = (dport_on && code >= 32) ? dev_dport : dev_data;
		end
		strobe <= (code == 35);
		if (code == 35) begin
			got <= {pulses, bad, acc};
		end
	end
endmodule : tdm_partner
`default_nettype wire

// File: verif/tb_tdm_2bd_bus_framing_dport.sv
// Bench: slave frames in every format, D port, master bit clock rates.
// Assumes the framer package and the far-side model tdm_partner.
`timescale 1ns/1ns
`default_nettype none
module tb_tdm_2bd_bus_framing_dport;
	import tdm_pkg::*;
	logic mclk, rst, master_select, dn_valid, dn_ready, up_valid;
	cfg_type cfg;
	word_type dn_word, up_word, p_word;
	logic bbc_out, bbc_oe, txo, txoe, rxo, rxoe, sdo, sdoe, dpo, dpclk;
	logic pclk, psync, sdata, ddata, strobe, dport;
	logic bclk_line, tx_line, rx_line;
	logic [22:0] got;
	logic [2:0] ch;
	fmt_type fmt;
	int num_errors = 0;
	int check_count = 0;
	int bit_cnt = 0;
	logic [22:0] bus_q[$];
	word_type up_q[$];
	assign bclk_line = bbc_oe ? bbc_out : pclk;
	assign tx_line = txoe ? txo : psync;
	assign rx_line = rxoe ? rxo : psync;
	tdm_2bd_bus_framing_dport u_tdm_2bd_bus_framing_dport (
		.mclk(mclk), .rst(rst), .master_select(master_select), .cfg(cfg),
		.dn_word(dn_word), .dn_valid(dn_valid), .dn_ready(dn_ready),
		.up_word(up_word), .up_valid(up_valid), .bus_bit_clock(bclk_line),
		.bus_bit_clock_out(bbc_out), .bus_bit_clock_oe(bbc_oe),
		.tx_frame_sync_in(tx_line), .tx_frame_sync_out(txo),
		.tx_frame_sync_oe(txoe), .rx_frame_sync_in(rx_line),
		.rx_frame_sync_out(rxo), .rx_frame_sync_oe(rxoe),
		.bus_data_in(sdata), .bus_data_out(sdo), .bus_data_out_oe(sdoe),
		.dport_data_in(ddata), .dport_data_out(dpo), .dport_gated_clock(dpclk)
	);
	tdm_partner u_tdm_partner (
		.bclk(pclk), .fmt(fmt), .ch(ch), .dport_on(dport), .in_word(p_word),
		.sync(psync), .sdata(sdata), .ddata(ddata), .dev_data(sdo),
		.dev_oe(sdoe), .dev_dport(dpo), .dev_dclk(dpclk), .got(got),
		.strobe(strobe)
	);
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic give_verdict();
		num_errors += bus_q.size() + up_q.size();
		$display("Comparisons %0d, mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : give_verdict
	always @(negedge strobe) begin
		if (bus_q.size() > 0) begin
			check(32'(got), 32'(bus_q.pop_front()));
		end
	end
	always @(posedge mclk) begin
		if (up_valid === 1'b1 && up_q.size() > 0) begin
			check(32'(up_word), 32'(up_q.pop_front()));
		end
	end
	always @(posedge bbc_out) begin
		bit_cnt++;
	end
	task automatic send(input word_type w);
		int t;
		t = 0;
		@(posedge mclk);
		dn_word <= w;
		dn_valid <= 1'b1;
		do begin
			@(posedge mclk);
			t++;
		end while (dn_ready !== 1'b1 && t < 400);
		dn_valid <= 1'b0;
		do begin
			@(posedge mclk);
			t++;
		end while (dn_ready !== 1'b1 && t < 800);
		if (t >= 800) begin
			num_errors++;
		end
	endtask : send
	task automatic frame_test(input fmt_type f, input logic [2:0] c,
			input logic dp);
		word_type dw;
		word_type uw;
		logic eff;
		dw = 18'($urandom);
		uw = 18'($urandom);
		eff = dp && !(f inside {FMT_LONG8, FMT_LONG10});
		@(posedge mclk);
		fmt <= f;
		ch <= c;
		dport <= eff;
		cfg.format_tsa_control[GCI_EN_BIT] <= (f == FMT_GCI);
		cfg.frame_clock_control[LONG_BIT] <= f inside {FMT_LONG10, FMT_LONG8};
		cfg.bus_format_control[EIGHT_BIT] <= f inside {FMT_SHORT8, FMT_LONG8};
		cfg.port_align_control[DPORT_EN_BIT] <= dp;
		cfg.din_d_slot_gci_select[GCI_SEL_HI:0] <= c;
		p_word <= uw;
		send(dw);
		repeat (3) @(negedge strobe);
		@(posedge strobe);
		bus_q.push_back({eff ? 4'h2 : 4'h0, 1'b0, dw});
		up_q.push_back(uw);
		@(negedge strobe);
		repeat (8) @(posedge mclk);
		$display("Test done: format %0d channel %0d dport %0d", f, c, dp);
	endtask : frame_test
	task automatic master_rate(input logic r512, input logic r2048,
			input logic [9:0] len, input logic lf);
		int n;
		@(posedge mclk);
		master_select <= 1'b1;
		cfg.frame_clock_control[LONG_BIT] <= lf;
		cfg.frame_clock_control[RATE_BIT] <= r512;
		cfg.bus_format_control[BR_RATE_BIT] <= r2048;
		repeat (3) @(posedge txo);
		n = bit_cnt;
		@(posedge txo);
		#1;
		check(32'(bit_cnt - n), 32'(len));
		check({29'h0, txoe, rxoe, rxo}, 32'h7);
		$display("Test done: master frame of %0d bit clocks", len);
	endtask : master_rate
	initial begin
		rst = 1'b1;
		master_select = 1'b0;
		cfg = CFG_RESET;
		cfg.serial_control_port = 1'b1;
		dn_word = WORD_RESET;
		dn_valid = 1'b0;
		fmt = FMT_SHORT10;
		ch = 3'h0;
		dport = 1'b0;
		p_word = WORD_RESET;
		void'($urandom(32'hc069));
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		frame_test(FMT_SHORT8, 3'h0, 1'b0);
		frame_test(FMT_SHORT10, 3'h0, 1'b0);
		frame_test(FMT_LONG8, 3'h0, 1'b0);
		frame_test(FMT_LONG10, 3'h0, 1'b1);
		frame_test(FMT_GCI, 3'h0, 1'b0);
		frame_test(FMT_GCI, 3'h1, 1'b1);
		frame_test(FMT_SHORT8, 3'h0, 1'b1);
		frame_test(FMT_SHORT10, 3'h0, 1'b1);
		master_rate(1'b0, 1'b0, LEN_2560K, 1'b0);
		master_rate(1'b0, 1'b1, LEN_2048K, 1'b0);
		master_rate(1'b1, 1'b1, LEN_512K, 1'b1);
		give_verdict();
	end
	initial begin
		#3000000;
		num_errors++;
		give_verdict();
	end
endmodule : tb_tdm_2bd_bus_framing_dport
`default_nettype wire
